// *** cal_ctrl_pkg.sv ***
// Shared constants and carrier structs for the converter control logic.
// Assumes one 250 MHz clock; counts are in clock cycles.
package cal_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] fs_adjust_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  // Control register field positions
  localparam int ctrl_ext_bit = 0;
  localparam int ctrl_res_hi_bit = 1;
  // Status register field positions
  localparam int st_run_bit = 0;
  localparam int st_oor_bit = 1;
  localparam int st_pd_bit = 2;
  localparam int st_fs_bit = 3;
  localparam int st_calib_bit = 4;
  localparam int st_term_bit = 5;
  // Reset values
  localparam logic [31:0] ctrl_rst = 32'h0000_0000;
  localparam logic [7:0] fs_adjust_rst = 8'h80;
  // Timing: delays in clock cycles
  localparam int cal_low_hold_def = 1280;
  localparam int cal_high_hold_def = 1280;
  localparam int short_delay_def = 16384;
  localparam int long_delay_def = 262144;
  localparam int cal_length_def = 8192;
  localparam int cnt_w = 24;
  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // Converter code limits
  localparam logic [8:0] code_max = 9'h0ff;

  // Control pin bundle from the host
  typedef struct packed {
    logic cal_req;
    logic delay_sel;
    logic fs_sel;
    logic pd;
  } ctrl_pins_s;

  // Status bundle toward the analog side
  typedef struct packed {
    logic analog_pd;
    logic cal_core;
    logic cal_term;
    logic fs_normal;
  } analog_ctl_s;
endpackage

// *** sync2.sv ***
// Two flip-flop synchroniser for one level.
// Assumes input asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module sync2
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  // Data
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // First stage read only by second
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (enable)
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** cal_ctrl.sv ***
// Control-pin logic: range flag, range select, calibration sequencing.
// Assumes pins are asynchronous; AXI4-Lite master is on clock.
// Functional notes
// - Flag out of range while result clipped
// - Pin picks normal or reduced full scale
// - Extended mode takes range from register
// - Calibrate at power-up and on request
// - Same procedure whether clock early or late
// - Running indicator high during calibration
// - Output word clock off during calibration
// - Power-on calibration after selectable delay
// - Exactly two delay lengths by select
// - Request high at power-up skips calibration
// - Start exactly high-hold after qualified rise
// - Power-on calibrates core and termination
// - Power-down at power-up stalls delay counter
// - Extended mode always uses short delay
// - No clock keeps analog powered down
// - Power-down waits for calibration finish
// - Power-down ignores calibration requests
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cal_ctrl
  import cal_ctrl_pkg::*;
#(
  parameter int cal_low_hold_cycles = cal_low_hold_def,
  parameter int cal_high_hold_cycles = cal_high_hold_def,
  parameter int short_delay_cycles = short_delay_def,
  parameter int long_delay_cycles = long_delay_def,
  parameter int cal_length_cycles = cal_length_def
)
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // Control pins from the host
  input wire ctrl_pins_s pins,
  // Converter core result, 9 bits with overflow
  input wire logic [8:0] raw_result,
  input wire logic raw_negative,
  // Word clock before gating
  input wire logic word_clock_in,
  // Range and calibration outputs
  output logic out_of_range_p,
  output logic out_of_range_n,
  output logic calibration_running,
  output logic output_word_clock,
  output analog_ctl_s analog_ctl,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  typedef enum logic [2:0] {st_delay, st_wait_low, st_wait_high,
    st_idle, st_cal, st_pd} state_e;

  state_e state_q;
  logic [cnt_w-1:0] cnt_q;
  logic [cnt_w-1:0] low_cnt_q;
  logic [cnt_w-1:0] high_cnt_q;
  logic [31:0] ctrl_q;
  logic [7:0] fs_adjust_q;
  logic power_on_q;
  logic calibrated_q;
  logic strap_done_q;
  logic [1:0] fill_q;
  logic req_s, dly_s, fs_s, pd_s, wclk_s;
  logic oor_q;
  logic fs_normal_q;
  logic term_cal_q;

  // Pin synchronisers
  sync2 u_sync_req (.clock(clock), .reset_n(reset_n), .enable(clock_en),
    .async_in(pins.cal_req), .sync_out(req_s));
  sync2 u_sync_dly (.clock(clock), .reset_n(reset_n), .enable(clock_en),
    .async_in(pins.delay_sel), .sync_out(dly_s));
  sync2 u_sync_fs (.clock(clock), .reset_n(reset_n), .enable(clock_en),
    .async_in(pins.fs_sel), .sync_out(fs_s));
  sync2 u_sync_pd (.clock(clock), .reset_n(reset_n), .enable(clock_en),
    .async_in(pins.pd), .sync_out(pd_s));

  // Mode and delay selection
  wire ext_mode = ctrl_q[ctrl_ext_bit];
  wire [cnt_w-1:0] delay_len = (ext_mode || !dly_s) ?
    cnt_w'(short_delay_cycles) : cnt_w'(long_delay_cycles);
  wire low_ok = low_cnt_q >= cnt_w'(cal_low_hold_cycles);
  wire high_done = high_cnt_q == cnt_w'(cal_high_hold_cycles - 1);
  wire cal_done = cnt_q == cnt_w'(cal_length_cycles - 1);
  wire delay_done = cnt_q == delay_len - cnt_w'(1);

  // Low-level counter for request qualification
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      low_cnt_q <= '0;
    else if (clock_en)
      low_cnt_q <= req_s ? '0 : (low_ok ? low_cnt_q : low_cnt_q + 1'b1);
  end

  // Strap of request level, caught once the synchronisers hold the pin
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_done_q <= 1'b0;
      power_on_q <= 1'b1;
      fill_q <= 2'h0;
    end
    else if (clock_en && !strap_done_q)
    begin
      if (fill_q == 2'h2)
      begin
        strap_done_q <= 1'b1;
        power_on_q <= !req_s;
      end
      else
        fill_q <= fill_q + 2'h1;
    end
  end

  // Calibration sequencer; same path for late clock start
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= st_delay;
      cnt_q <= '0;
      high_cnt_q <= '0;
      calibrated_q <= 1'b0;
      term_cal_q <= 1'b0;
    end
    else if (clock_en && strap_done_q)
    begin
      case (state_q)
        st_delay:
          if (!power_on_q)
            state_q <= st_wait_low;
          else if (!pd_s)
          begin
            cnt_q <= delay_done ? '0 : cnt_q + 1'b1;
            if (delay_done)
            begin
              state_q <= st_cal;
              term_cal_q <= 1'b1;
            end
          end
        st_wait_low, st_idle:
          if (pd_s)
            state_q <= st_pd;
          else if (req_s && low_ok)
          begin
            high_cnt_q <= '0;
            state_q <= st_wait_high;
          end
        st_wait_high:
          if (!req_s || pd_s)
            state_q <= pd_s ? st_pd : st_idle;
          else if (high_done)
          begin
            cnt_q <= '0;
            term_cal_q <= 1'b0;
            state_q <= st_cal;
          end
          else
            high_cnt_q <= high_cnt_q + 1'b1;
        st_cal:
          if (cal_done)
          begin
            cnt_q <= '0;
            calibrated_q <= 1'b1;
            state_q <= pd_s ? st_pd : st_idle;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        st_pd:
          if (!pd_s)
            state_q <= st_idle;
        default:
          state_q <= st_idle;
      endcase
    end
  end

  wire running = state_q == st_cal;

  // Range flag and full scale selection registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oor_q <= 1'b0;
      fs_normal_q <= 1'b1;
      calibration_running <= 1'b0;
      output_word_clock <= 1'b0;
    end
    else if (clock_en)
    begin
      oor_q <= raw_negative || (raw_result > code_max);
      fs_normal_q <= ext_mode ? ctrl_q[ctrl_res_hi_bit] : fs_s;
      calibration_running <= running;
      output_word_clock <= word_clock_in && !running;
    end
  end

  assign out_of_range_p = oor_q;
  assign out_of_range_n = !oor_q;
  // Analog side: powered down before first edges and in the st_pd state
  assign analog_ctl = '{analog_pd: !strap_done_q || state_q == st_pd,
    cal_core: running,
    cal_term: running && term_cal_q,
    fs_normal: fs_normal_q};

  // AXI4-Lite write channel
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  assign s_awready = !aw_held_q && !s_bvalid;
  assign s_wready = !w_held_q && !s_bvalid;
  wire do_write = aw_held_q && w_held_q && !s_bvalid;
  wire wr_ctrl = awaddr_q == ctrl_off;
  wire wr_fs = awaddr_q == fs_adjust_off;
  wire wr_map = wr_ctrl || wr_fs || awaddr_q == status_off;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_bvalid <= 1'b0;
      s_bresp <= resp_okay;
      ctrl_q <= ctrl_rst;
      fs_adjust_q <= fs_adjust_rst;
    end
    else if (clock_en)
    begin
      if (s_awvalid && s_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_map ? resp_okay : resp_slverr;
        if (wr_ctrl && wstrb_q[0])
          ctrl_q <= {30'h0, wdata_q[1:0]};
        if (wr_fs && wstrb_q[0])
          fs_adjust_q <= wdata_q[7:0];
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  wire [31:0] status_word = {26'h0, term_cal_q, calibrated_q,
    fs_normal_q, pd_s, oor_q, running};
  wire rd_ctrl = s_araddr == ctrl_off;
  wire rd_fs = s_araddr == fs_adjust_off;
  wire rd_st = s_araddr == status_off;
  wire [31:0] rd_word = rd_ctrl ? ctrl_q :
    rd_fs ? {24'h0, fs_adjust_q} : rd_st ? status_word : 32'h0;
  assign s_arready = !s_rvalid;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= resp_okay;
    end
    else if (clock_en)
    begin
      if (s_arvalid && s_arready)
      begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_word;
        s_rresp <= (rd_ctrl || rd_fs || rd_st) ? resp_okay : resp_slverr;
      end
      else if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
    end
  end

  // Checks
  sequence s_req_dropped;
    state_q == st_wait_high && clock_en && !req_s;
  endsequence
  a_run_matches_state: assert property (@(posedge clock) disable iff
    (!reset_n) clock_en |=> calibration_running == $past(running))
    else $error("running flag does not follow calibration state");
  a_word_clock_gated: assert property (@(posedge clock) disable iff
    (!reset_n) calibration_running |-> !output_word_clock)
    else $error("word clock active during calibration");
  a_pd_ignores_req: assert property (@(posedge clock) disable iff
    (!reset_n) state_q == st_pd |=> state_q != st_cal)
    else $error("calibration started from power down");
  a_cal_not_cut: assert property (@(posedge clock) disable iff
    (!reset_n) running && !cal_done |=> running || !clock_en)
    else $error("calibration cut short");
  a_short_pulse_drop: assert property (@(posedge clock) disable iff
    (!reset_n) s_req_dropped |=> state_q != st_cal)
    else $error("short request pulse started calibration");
  a_range_flag_pair: assert property (@(posedge clock) disable iff
    (!reset_n) out_of_range_p != out_of_range_n)
    else $error("range flag lines not complementary");
  a_delay_held_pd: assert property (@(posedge clock) disable iff
    (!reset_n) state_q == st_delay && pd_s && power_on_q && clock_en
    |=> cnt_q == $past(cnt_q))
    else $error("delay counter ran in power down");
  a_ext_fs_reg: assert property (@(posedge clock) disable iff
    (!reset_n) clock_en && ext_mode |=>
    fs_normal_q == $past(ctrl_q[ctrl_res_hi_bit]))
    else $error("extended range not from register");
  a_pin_fs_normal: assert property (@(posedge clock) disable iff
    (!reset_n) clock_en && !ext_mode |=> fs_normal_q == $past(fs_s))
    else $error("range does not follow pin");
endmodule
`default_nettype wire

// *** host_model.sv ***
// Host model driving the converter control pins.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import cal_ctrl_pkg::*;
(
  // Clock
  input wire logic clock,
  // Control pins
  output var ctrl_pins_s pins
);
  // Load every pin at once, used while reset is held
  task automatic load(input ctrl_pins_s v);
    pins <= v;
  endtask

  // Change one pin on the next edge
  task automatic put(input int i, input logic v);
    @(posedge clock);
    pins[i] <= v;
  endtask

  // Request: low for lo cycles, then raise and leave high
  task automatic request(input int lo);
    put(3, 1'h0);
    repeat (lo) @(posedge clock);
    pins[3] <= 1'h1;
  endtask

  // Resync pin not modelled, so never raised during calibration
  // Quiet pins at time zero
  initial pins = '0;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the converter control logic.
// Assumes host_model and cal_ctrl_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cal_ctrl_pkg::*;
  localparam int lo_h = 8, hi_h = 4, sh_d = 16, lg_d = 64, ln_c = 32;
  logic clock, reset_n, clock_en, word_clock_in, raw_negative;
  logic [8:0] raw_result;
  ctrl_pins_s pins;
  logic out_of_range_p, out_of_range_n, calibration_running;
  logic output_word_clock;
  analog_ctl_s analog_ctl;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, r;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int n_fail = 0;
  int checked = 0;
  int n;

  // Device with short counts, and the host
  cal_ctrl #(.cal_low_hold_cycles(lo_h), .cal_high_hold_cycles(hi_h),
    .short_delay_cycles(sh_d), .long_delay_cycles(lg_d),
    .cal_length_cycles(ln_c)) i_dut (.clock, .reset_n, .clock_en,
    .pins, .raw_result, .raw_negative, .word_clock_in, .out_of_range_p,
    .out_of_range_n, .calibration_running, .output_word_clock,
    .analog_ctl, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  host_model i_host (.clock, .pins);

  // Clock and free-running word clock
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) word_clock_in <= ~word_clock_in;

  // Hang guard
  initial
  begin
    #100000;
    n_fail++;
    print_verdict();
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Reset with pins strapped, clock enable chosen
  task automatic rst(input logic [3:0] p, input logic en);
    @(posedge clock);
    reset_n <= 1'h0;
    clock_en <= en;
    i_host.load(ctrl_pins_s'(p));
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
  endtask

  // Count cycles until the running flag shows
  task automatic wait_run(input int lim, output int k);
    k = 0;
    while (calibration_running !== 1'h1 && k < lim)
    begin
      @(negedge clock);
      k++;
    end
  endtask

  // Measure the running span and watch the word clock
  task automatic run_len(input int exp);
    int k;
    logic wc;
    k = 0;
    wc = 1'h0;
    while (calibration_running === 1'h1 && k < 1000)
    begin
      wc = wc | output_word_clock;
      @(negedge clock);
      k++;
    end
    chk("word clock", wc, 0);
    chk("cal length", k, exp);
  endtask

  // One bus access; read data in d, response in r
  task automatic axi(input logic w, input logic [7:0] a,
    input logic [31:0] v);
    logic ta, tw, b;
    b = 1'h0;
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= v;
    {s_awvalid, s_wvalid, s_bready} <= {3{w}};
    {s_arvalid, s_rready} <= {2{!w}};
    while (!b)
    begin
      @(negedge clock);
      ta = w ? s_awready : s_arready;
      tw = s_wready;
      b = w ? s_bvalid : s_rvalid;
      d = s_rdata;
      r = w ? s_bresp : s_rresp;
      @(posedge clock);
      if (ta) {s_awvalid, s_arvalid} <= 2'h0;
      if (tw) s_wvalid <= 1'h0;
    end
    {s_bready, s_rready} <= 2'h0;
    @(posedge clock);
  endtask

  // Power-on calibration, optionally with a late clock
  task automatic pwr(input logic [3:0] p, input int dl, input int off);
    rst(p, off == 0);
    repeat (off) @(posedge clock);
    if (off)
      chk("analog off", analog_ctl.analog_pd, 1);
    clock_en <= 1'h1;
    wait_run(dl + 20, n);
    chk("cal delay", n >= dl && n <= dl + 6, 1);
    chk("core term", {analog_ctl.cal_core, analog_ctl.cal_term}, 3);
    run_len(ln_c);
  endtask

  // Request strapped high, then requests clean and noisy
  task automatic t_strap();
    rst(4'ha, 1'h1);
    wait_run(lg_d + 20, n);
    chk("strap skip", n, lg_d + 20);
    i_host.request(12);
    wait_run(20, n);
    chk("req start", n >= hi_h && n <= hi_h + 5, 1);
    run_len(ln_c);
    i_host.request(12);
    i_host.put(3, 1'h0);
    wait_run(20, n);
    chk("short pulse", n, 20);
  endtask

  // Power-down at power-up, mid calibration, and with a request
  task automatic t_pd();
    rst(4'h3, 1'h1);
    wait_run(3 * sh_d, n);
    chk("pd holds", n, 3 * sh_d);
    i_host.put(0, 1'h0);
    wait_run(sh_d + 20, n);
    chk("pd release", n >= sh_d && n <= sh_d + 8, 1);
    i_host.put(0, 1'h1);
    @(negedge clock);
    run_len(ln_c - 1);
    i_host.request(12);
    wait_run(20, n);
    chk("pd ignores", n, 20);
  endtask

  // Range by pin and by register, register access
  task automatic t_regs();
    rst(4'h0, 1'h1);
    repeat (5) @(posedge clock);
    chk("reduced", analog_ctl.fs_normal, 0);
    i_host.put(1, 1'h1);
    repeat (5) @(posedge clock);
    chk("normal", analog_ctl.fs_normal, 1);
    axi(1'h0, fs_adjust_off, 0);
    chk("adj reset", d[7:0], fs_adjust_rst);
    axi(1'h1, fs_adjust_off, 32'h5a);
    axi(1'h0, fs_adjust_off, 0);
    chk("adj value", d[7:0], 8'h5a);
    axi(1'h1, ctrl_off, 32'h1);
    chk("ext reduced", analog_ctl.fs_normal, 0);
    axi(1'h1, ctrl_off, 32'h3);
    i_host.put(1, 1'h0);
    repeat (5) @(posedge clock);
    chk("ext normal", analog_ctl.fs_normal, 1);
    axi(1'h0, 8'h0c, 0);
    chk("unmapped", r, resp_slverr);
  endtask

  // Clip flag at the code limits
  task automatic t_oor();
    logic [9:0] st [4] = '{10'h0ff, 10'h100, 10'h200, 10'h000};
    for (int i = 0; i < 4; i++)
    begin
      {raw_negative, raw_result} <= st[i];
      repeat (2) @(posedge clock);
      chk("clip", {out_of_range_p, out_of_range_n},
        (i == 1 || i == 2) ? 2 : 1);
    end
  endtask

  // Main sequence
  initial
  begin
    {reset_n, word_clock_in, raw_negative, raw_result} = '0;
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid} = '0;
    {s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hf;
    clock_en = 1'h1;
    pwr(4'h2, sh_d, 0);
    pwr(4'h6, lg_d, 0);
    pwr(4'h2, sh_d, 10);
    t_strap();
    t_pd();
    t_regs();
    t_oor();
    print_verdict();
  end
endmodule
`default_nettype wire
